// file: rtl/wdt_pkg.sv
// Purpose: shared constants, types and helpers for the windowed watchdog
// Assumes: 8-bit register fields in the low byte of 32-bit bus words
// Notes: timeouts are counted in watchdog clock ticks, not system clocks
package wdt_pkg;

    // register byte addresses
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_PROTECT = 8'h08;
    localparam logic [7:0] OFS_CLEAR = 8'h0C;

    // status fields
    localparam int STATUS_LOCK_BIT = 7;
    localparam int STATUS_SYNC_BIT = 0;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    // unlock key; value is arbitrary
    localparam logic [7:0] PROTECT_KEY = 8'hD8;
    // protected write must follow the key within this many bus clocks
    localparam logic [2:0] PROT_WINDOW_CYC = 3'h4;
    // a clear is applied at the third tick after it is written
    localparam logic [1:0] CLR_SYNC_TICKS = 2'h2;

    // watchdog clock and shortest timeout
    localparam int TICK_HZ = 1000;
    localparam int OSC_HZ = 32768;
    localparam int BASE_TIMEOUT_MS = 8;
    localparam int CNT_W = 14;
    localparam logic [CNT_W-1:0] BASE_TICKS = CNT_W'(BASE_TIMEOUT_MS * TICK_HZ / 1000);
    localparam logic [3:0] CODE_MAX = 4'hB;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] window;
        logic [3:0] period;
    } ctrl_t;

    typedef enum logic [1:0] {ST_OFF, ST_NORMAL, ST_CLOSED, ST_OPEN} wd_state_t;

    // code 1 gives 8 ticks, each further code doubles; reserved codes act as the longest
    function automatic logic [CNT_W-1:0] ticks_for(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        if (c == 4'h0) begin
            return '0;
        end
        return CNT_W'(BASE_TICKS << (c - 4'h1));
    endfunction

endpackage

// file: rtl/wdt_tick_sync.sv
// Purpose: bring the slow oscillator level into the bus clock as a tick pulse
// Assumes: oscillator level is far slower than aclk
// Notes: first flop feeds only the second flop
`timescale 1ns/10ps
`default_nettype none
module wdt_tick_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic osc_level,
    output logic tick
);
    logic meta_r;
    logic sync_r;
    logic last_r;
    logic tick_nxt;

    always_comb begin
        tick_nxt = sync_r & ~last_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // primed high: a level already high at release is no tick;
            // a rising edge inside reset is dropped instead
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            last_r <= 1'b1;
            tick <= 1'b0;
        end else begin
            meta_r <= osc_level;
            sync_r <= meta_r;
            last_r <= sync_r;
            tick <= tick_nxt;
        end
    end
endmodule // wdt_tick_sync
`default_nettype wire

// file: rtl/windowed_watchdog_timer.sv
// Purpose: windowed watchdog with protected, lockable settings on AXI4-Lite
// Assumes: osc_1khz is the 1 kHz watchdog counter clock as a level
// Notes: counting state lives in aclk, advanced by synchronised ticks
//
// How it works
// - unclaimed timeout raises system reset request
// - counter advances on slow oscillator ticks only
// - eleven timeouts, 8 ms to 8 s
// - window mode resets on early or late clear
// - clear instruction restarts the running timeout
// - normal or window mode from control register
// - keeps counting in active and sleep modes
// - counting independent of processor clock health; here the counter state is clocked by aclk, and oscillator ticks only pace it
// - closed period starts after first clear
// - control writes pass a synchroniser before use
// - settings change only after timed unlock
// - lock stops further setting changes
// - nonzero window code sets closed duration
// - nonzero period enables and sets timeout
// - lock sets only, clears in debug, fuse-set
// - clear syncs 2-3 ticks, extra clears ignored
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic osc_1khz,
    input wire logic debug_mode,
    input wire logic [7:0] fuse_ctrl,
    output logic sys_reset_req
);
    logic tick;
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [7:0] awaddr_r, awaddr_nxt, wbyte_r, wbyte_nxt;
    logic wstrb0_r, wstrb0_nxt;
    logic awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    ctrl_t ctrl_r, ctrl_nxt, act_r, act_nxt;
    logic lock_r, lock_nxt, cfg_pend_r, cfg_pend_nxt, boot_done_r, boot_done_nxt;
    logic [2:0] prot_cnt_r, prot_cnt_nxt;
    logic clr_pend_r, clr_pend_nxt;
    logic [1:0] clr_age_r, clr_age_nxt;
    wd_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt, cnt_inc;
    logic rst_nxt;
    logic wr_fire, wr_ok, ctrl_wr, clr_write, clr_apply, fire;

    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'h0};
        return (w == OFS_CTRL) || (w == OFS_STATUS) || (w == OFS_PROTECT) || (w == OFS_CLEAR);
    endfunction

    wdt_tick_sync u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_level(osc_1khz),
        .tick(tick)
    );

    always_comb begin
        // bus slave
        aw_have_nxt = aw_have_r | (awvalid & awready);
        awaddr_nxt = (awvalid & awready) ? 8'(awaddr) : awaddr_r;
        w_have_nxt = w_have_r | (wvalid & wready);
        wbyte_nxt = (wvalid & wready) ? wdata[7:0] : wbyte_r;
        wstrb0_nxt = (wvalid & wready) ? wstrb[0] : wstrb0_r;
        wr_fire = aw_have_r & w_have_r & ~bvalid;
        wr_ok = wr_fire & is_mapped(awaddr_r) & wstrb0_r;
        bvalid_nxt = bvalid & ~bready;
        bresp_nxt = bresp;
        if (wr_fire) begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
        end
        awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
        wready_nxt = ~w_have_nxt & ~bvalid_nxt;
        rvalid_nxt = rvalid & ~rready;
        rdata_nxt = rdata;
        rresp_nxt = rresp;
        if (arvalid & arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = is_mapped(8'(araddr)) ? RESP_OKAY : RESP_SLVERR;
            rdata_nxt = '0;
            if ({araddr[7:2], 2'h0} == OFS_CTRL) begin
                rdata_nxt[7:0] = ctrl_r;
            end else if ({araddr[7:2], 2'h0} == OFS_STATUS) begin
                rdata_nxt[STATUS_LOCK_BIT] = lock_r;
                rdata_nxt[STATUS_SYNC_BIT] = cfg_pend_r | clr_pend_r;
            end
        end
        arready_nxt = ~rvalid_nxt;

        // settings, protection and lock
        ctrl_nxt = ctrl_r;
        lock_nxt = lock_r;
        cfg_pend_nxt = cfg_pend_r;
        boot_done_nxt = 1'b1;
        prot_cnt_nxt = (prot_cnt_r != 3'h0) ? prot_cnt_r - 3'h1 : 3'h0;
        ctrl_wr = 1'b0;
        if (!boot_done_r) begin
            ctrl_nxt = ctrl_t'(fuse_ctrl);
            cfg_pend_nxt = 1'b1;
            lock_nxt = (fuse_ctrl[3:0] != 4'h0);
        end else if (wr_ok) begin
            if (awaddr_r[7:2] == OFS_PROTECT[7:2] && wbyte_r == PROTECT_KEY) begin
                prot_cnt_nxt = PROT_WINDOW_CYC;
            end else if (awaddr_r[7:2] == OFS_CTRL[7:2]) begin
                // refused while locked, unprotected, or still synchronising
                ctrl_wr = (prot_cnt_r != 3'h0) & ~lock_r & ~cfg_pend_r;
                if (ctrl_wr) begin
                    ctrl_nxt = ctrl_t'(wbyte_r);
                    cfg_pend_nxt = 1'b1;
                end
            end else if (awaddr_r[7:2] == OFS_STATUS[7:2] && prot_cnt_r != 3'h0) begin
                if (wbyte_r[STATUS_LOCK_BIT]) begin
                    lock_nxt = 1'b1;
                end else if (debug_mode) begin
                    lock_nxt = 1'b0;
                end
            end
        end

        // clear instruction synchronisation
        clr_write = wr_ok & (awaddr_r[7:2] == OFS_CLEAR[7:2]);
        clr_pend_nxt = clr_pend_r;
        clr_age_nxt = clr_age_r;
        clr_apply = clr_pend_r & tick & (clr_age_r == CLR_SYNC_TICKS);
        if (clr_pend_r & tick) begin
            clr_age_nxt = clr_age_r + 2'h1;
        end
        if (clr_apply) begin
            clr_pend_nxt = 1'b0;
        end
        // a clear during synchronisation is dropped
        if (clr_write & ~clr_pend_r & (state_r != ST_OFF)) begin
            clr_pend_nxt = 1'b1;
            clr_age_nxt = 2'h0;
        end

        // counter domain, advanced only by oscillator ticks; no sleep or
        // clock-fail input gates it
        act_nxt = act_r;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        cnt_inc = cnt_r + CNT_W'(1);
        fire = 1'b0;
        if (debug_mode) begin
            // halted core: counter held at zero, first closed period skipped
            cnt_nxt = '0;
            state_nxt = (act_r.period == 4'h0) ? ST_OFF : ST_NORMAL;
        end else if (tick & cfg_pend_r) begin
            act_nxt = ctrl_r;
            cfg_pend_nxt = ctrl_wr;
            cnt_nxt = '0;
            state_nxt = (ctrl_r.period == 4'h0) ? ST_OFF : ST_NORMAL;
        end else if (tick) begin
            case (state_r)
                ST_NORMAL: begin
                    if (clr_apply && act_r.window != 4'h0) begin
                        state_nxt = ST_CLOSED;
                        cnt_nxt = '0;
                    end else if (clr_apply) begin
                        cnt_nxt = '0;
                    end else if (cnt_inc >= ticks_for(act_r.period)) begin
                        fire = 1'b1;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_inc;
                    end
                end
                ST_CLOSED: begin
                    if (clr_apply) begin
                        fire = 1'b1;
                        state_nxt = ST_NORMAL;
                        cnt_nxt = '0;
                    end else if (cnt_inc >= ticks_for(act_r.window)) begin
                        state_nxt = ST_OPEN;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_inc;
                    end
                end
                ST_OPEN: begin
                    if (clr_apply) begin
                        state_nxt = ST_CLOSED;
                        cnt_nxt = '0;
                    end else if (cnt_inc >= ticks_for(act_r.period)) begin
                        fire = 1'b1;
                        state_nxt = ST_NORMAL;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_inc;
                    end
                end
                default: begin
                    cnt_nxt = '0;
                end
            endcase
        end
        // held until the next tick so the pulse spans a whole watchdog cycle
        rst_nxt = fire | (sys_reset_req & ~tick);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wbyte_r <= 8'h00;
            wstrb0_r <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
            ctrl_r <= ctrl_t'(CTRL_RESET);
            act_r <= ctrl_t'(CTRL_RESET);
            lock_r <= 1'b0;
            cfg_pend_r <= 1'b0;
            boot_done_r <= 1'b0;
            prot_cnt_r <= 3'h0;
            clr_pend_r <= 1'b0;
            clr_age_r <= 2'h0;
            state_r <= ST_OFF;
            cnt_r <= '0;
            sys_reset_req <= 1'b0;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awaddr_r <= awaddr_nxt;
            wbyte_r <= wbyte_nxt;
            wstrb0_r <= wstrb0_nxt;
            awready <= awready_nxt;
            wready <= wready_nxt;
            bvalid <= bvalid_nxt;
            bresp <= bresp_nxt;
            arready <= arready_nxt;
            rvalid <= rvalid_nxt;
            rdata <= rdata_nxt;
            rresp <= rresp_nxt;
            ctrl_r <= ctrl_nxt;
            act_r <= act_nxt;
            lock_r <= lock_nxt;
            cfg_pend_r <= cfg_pend_nxt;
            boot_done_r <= boot_done_nxt;
            prot_cnt_r <= prot_cnt_nxt;
            clr_pend_r <= clr_pend_nxt;
            clr_age_r <= clr_age_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sys_reset_req <= rst_nxt;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    timeout_reset_a: assert property (
        tick && !debug_mode && !cfg_pend_r && state_r == ST_NORMAL && !clr_apply
        && cnt_inc >= ticks_for(act_r.period) |=> sys_reset_req [*2])
        else $error("timeout did not raise reset request");
    tick_paced_a: assert property (
        cnt_r != $past(cnt_r) |-> $past(tick) || $past(debug_mode))
        else $error("counter moved without a watchdog tick");
    count_bound_a: assert property (
        state_r == ST_NORMAL |-> cnt_r < ticks_for(act_r.period) && cnt_r < 14'h2000)
        else $error("counter beyond selected timeout");
    early_clear_a: assert property (
        clr_apply && !debug_mode && !cfg_pend_r && state_r == ST_CLOSED
        |=> sys_reset_req && state_r == ST_NORMAL)
        else $error("clear in closed period not punished");
    clear_restart_a: assert property (
        clr_apply && !debug_mode && !cfg_pend_r && state_r == ST_NORMAL
        && act_r.window == 4'h0 |=> cnt_r == '0 && !sys_reset_req)
        else $error("clear did not restart timeout");
    mode_apply_a: assert property (
        tick && cfg_pend_r && !debug_mode
        |=> state_r == ((act_r.period == 4'h0) ? ST_OFF : ST_NORMAL) && act_r == $past(ctrl_r))
        else $error("settings not applied at tick");
    first_clear_a: assert property (
        clr_apply && !debug_mode && !cfg_pend_r && state_r == ST_NORMAL
        && act_r.window != 4'h0 |=> state_r == ST_CLOSED)
        else $error("closed period not started by first clear");
    ctrl_sync_a: assert property (
        ctrl_wr |=> cfg_pend_r && act_r == $past(act_r))
        else $error("control write bypassed synchroniser");
    prot_guard_a: assert property (
        boot_done_r && $past(boot_done_r) && ctrl_r != $past(ctrl_r)
        |-> $past(prot_cnt_r) != 3'h0 && !$past(lock_r))
        else $error("settings changed without unlock");
    lock_sticky_a: assert property (
        boot_done_r && lock_r && !debug_mode |=> lock_r)
        else $error("lock cleared outside debug");
    clear_ignore_a: assert property (
        clr_pend_r && clr_write && !tick |=> clr_pend_r && clr_age_r == $past(clr_age_r))
        else $error("second clear disturbed synchronisation");
    reset_width_a: assert property (
        sys_reset_req && !tick |=> sys_reset_req)
        else $error("reset request shorter than a tick");
    open_follows_a: assert property (
        tick && !debug_mode && !cfg_pend_r && state_r == ST_CLOSED && !clr_apply
        && cnt_inc >= ticks_for(act_r.window) |=> state_r == ST_OPEN)
        else $error("open period did not follow closed period");

    timeout_seen_c: cover property (fire && state_r == ST_NORMAL);
    early_clear_c: cover property (clr_apply && state_r == ST_CLOSED);
    open_clear_c: cover property (clr_apply && state_r == ST_OPEN);
    locked_write_c: cover property (wr_ok && lock_r && awaddr_r == OFS_CTRL);
endmodule // windowed_watchdog_timer
`default_nettype wire

// file: tb/core_model.sv
// Purpose: processor-side bus master issuing register writes and clears
// Assumes: bready and rready are held high by the bench
// Notes: stuck rises when the slave never answers within the bound
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic stuck
);
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wstrb = 4'h0;
        wvalid = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        stuck = 1'b0;
    end

    // address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic pa;
        logic pw;
        int n;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (pa && awready) begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
            if (bvalid) break;
        end
        if (n == 64) stuck <= 1'b1;
    endtask

    task automatic rd(input logic [7:0] a);
        logic pa;
        int n;
        pa = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (pa && arready) begin
                pa = 1'b0;
                arvalid <= 1'b0;
            end
            if (rvalid) break;
        end
        if (n == 64) stuck <= 1'b1;
    endtask
endmodule // core_model
`default_nettype wire

// file: tb/tb_windowed_watchdog_timer.sv
// Purpose: self-checking bench for the windowed watchdog
// Assumes: oscillator sped up to 16 aclk per tick to keep runs short
// Notes: reset timing is judged in oscillator edges with sync slack
`timescale 1ns/10ps
`default_nettype none
module tb_windowed_watchdog_timer import wdt_pkg::*;;
    logic aclk, aresetn, osc, debug_mode, stuck, rst_d;
    logic awvalid, wvalid, awready, wready, bvalid, arvalid, arready, rvalid, sys_reset_req;
    logic [7:0] awaddr, araddr, fuse_ctrl;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    logic [47:0] exp_t[$];
    logic [15:0] ticks, lfsr;
    int n_mismatch, comparisons, i;

    windowed_watchdog_timer dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(1'b1), .osc_1khz(osc), .debug_mode(debug_mode), .fuse_ctrl(fuse_ctrl),
        .sys_reset_req(sys_reset_req));
    core_model core (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .awready(awready), .wready(wready), .bvalid(bvalid),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .stuck(stuck));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // offset keeps oscillator edges away from aclk edges
    initial begin
        osc = 1'b0;
        #13;
        forever #400 osc = ~osc;
    end
    always @(posedge osc) ticks <= ticks + 16'h0001;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_bus(input string what, input logic [33:0] e, input logic [33:0] s);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask

    // an unexpected request arrives with an unknown note and fails
    task automatic chk_time(input logic [47:0] e);
        logic [15:0] el;
        el = ticks - e[47:32];
        comparisons++;
        if (((el >= e[31:16]) && (el <= e[15:0])) !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH reset ticks expected %0d..%0d seen %0d", e[31:16], e[15:0], el);
        end
    endtask

    always @(posedge aclk) begin
        rst_d <= sys_reset_req;
        if (bvalid === 1'b1) chk_bus("bresp", {32'h0, exp_b.size() ? exp_b.pop_front() : 2'bxx},
            {32'h0, bresp});
        if (rvalid === 1'b1) chk_bus("read", exp_r.size() ? exp_r.pop_front() : 34'bx,
            {rresp, rdata});
        if (sys_reset_req === 1'b1 && rst_d !== 1'b1) chk_time(exp_t.size() ?
            exp_t.pop_front() : 48'bx);
        if (stuck === 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic wr_x(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        core.wr(a, {24'h000000, d}, 4'hF);
    endtask
    task automatic rd_x(input logic [7:0] a, input logic [7:0] d);
        exp_r.push_back({RESP_OKAY, 24'h000000, d});
        core.rd(a);
    endtask
    task automatic pwr(input logic [7:0] a, input logic [7:0] d);
        wr_x(OFS_PROTECT, PROTECT_KEY, RESP_OKAY);
        wr_x(a, d, RESP_OKAY);
    endtask
    task automatic clr();
        lfsr = lfsr_next(lfsr);
        exp_b.push_back(RESP_OKAY);
        core.wr(OFS_CLEAR, {16'h0000, lfsr}, {lfsr[2:0], 1'b1});
    endtask
    task automatic expect_rst(input logic [15:0] lo, input logic [15:0] hi);
        exp_t.push_back({ticks, lo, hi});
    endtask
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge osc);
        @(posedge aclk);
    endtask
    task automatic wait_rst();
        int n;
        for (n = 0; n < 20000 && exp_t.size() != 0; n++) @(posedge aclk);
        if (exp_t.size() != 0) begin
            n_mismatch++;
            $display("MISMATCH reset request expected 1 seen 0");
            tally_and_finish();
        end
    endtask
    task automatic off();
        wait_ticks(1);
        pwr(OFS_CTRL, 8'h00);
        wait_ticks(2);
    endtask

    initial begin
        aresetn = 1'b0;
        debug_mode = 1'b0;
        fuse_ctrl = 8'h00;
        ticks = 16'h0000;
        lfsr = 16'h0004;
        n_mismatch = 0;
        comparisons = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_x(OFS_CTRL, 8'h00);
        // boot value still waits for its first tick
        rd_x(OFS_STATUS, 8'h01);
        wr_x(8'h10, 8'h01, RESP_SLVERR);
        wr_x(OFS_CTRL, 8'h01, RESP_OKAY);
        wr_x(OFS_PROTECT, PROTECT_KEY, RESP_OKAY);
        repeat (8) @(posedge aclk);
        wr_x(OFS_CTRL, 8'h01, RESP_OKAY);
        wait_ticks(3);
        rd_x(OFS_CTRL, 8'h00);
        for (i = 1; i <= 7; i++) begin
            expect_rst(16'h0008 << (i - 1), (16'h0008 << (i - 1)) + 16'h0002);
            pwr(OFS_CTRL, 8'(i));
            wait_rst();
            off();
        end
        pwr(OFS_CTRL, 8'h02);
        wait_ticks(2);
        rd_x(OFS_CTRL, 8'h02);
        for (i = 0; i < 4; i++) begin
            clr();
            wait_ticks(10);
        end
        expect_rst(16'h0011, 16'h0014);
        clr();
        wait_rst();
        off();
        // first clear comes before the closed span would end if it began at enable
        pwr(OFS_CTRL, 8'h11);
        wait_ticks(2);
        clr();
        wait_ticks(10);
        expect_rst(16'h0011, 16'h0014);
        clr();
        wait_ticks(1);
        clr();
        wait_rst();
        off();
        pwr(OFS_CTRL, 8'h11);
        wait_ticks(2);
        clr();
        wait_ticks(4);
        expect_rst(16'h0001, 16'h0004);
        clr();
        wait_rst();
        off();
        pwr(OFS_STATUS, 8'h80);
        rd_x(OFS_STATUS, 8'h80);
        pwr(OFS_CTRL, 8'h05);
        wait_ticks(2);
        rd_x(OFS_CTRL, 8'h00);
        pwr(OFS_STATUS, 8'h00);
        rd_x(OFS_STATUS, 8'h80);
        debug_mode <= 1'b1;
        pwr(OFS_STATUS, 8'h00);
        rd_x(OFS_STATUS, 8'h00);
        debug_mode <= 1'b0;
        aresetn <= 1'b0;
        fuse_ctrl <= 8'h01;
        repeat (16) @(posedge aclk);
        expect_rst(16'h0007, 16'h000A);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // read before any tick can apply the fuse value
        rd_x(OFS_STATUS, 8'h81);
        rd_x(OFS_CTRL, 8'h01);
        wait_rst();
        tally_and_finish();
    end
endmodule // tb_windowed_watchdog_timer
`default_nettype wire
